/* File: verilog/refresh_pkg.sv */
// Purpose: shared constants for the refresh and power-save unit and its bus partner
// Assumes: 16-bit register port on the device, APB on the controller
// Notes: offsets are byte offsets within the peripheral block
package refresh_pkg;
  // ---------------------------------------------------------------
  // device register map
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_PARTITION = 8'he0;
  localparam logic [7:0] OFS_INTERVAL = 8'he2;
  localparam logic [7:0] OFS_ENABLE_COUNT = 8'he4;
  localparam logic [7:0] OFS_POWER_SAVE = 8'hf0;
  localparam int ENABLE_BIT = 15;
  localparam int PART_LSB = 9;
  localparam int DIV_MSB = 2;
  localparam logic [8:0] ROW_RESET = 9'h001;
  localparam logic [8:0] ROW_TAPS = 9'h110;
  localparam logic [8:0] COUNT_EXPIRE = 9'h001;
  localparam logic [8:0] MIN_INTERVAL = 9'h012;
  localparam logic [3:0] STRAP_CYCLES = 4'h8;
  // ---------------------------------------------------------------
  // controller register map (APB)
  // ---------------------------------------------------------------
  localparam logic [7:0] APB_CMD = 8'h00;
  localparam logic [7:0] APB_RDATA = 8'h04;
  localparam logic [7:0] APB_CTRL = 8'h08;
  localparam logic [7:0] APB_STATUS = 8'h0c;
  localparam int CMD_WRITE_BIT = 24;
  localparam int CMD_READ_BIT = 25;
  localparam int CTRL_TIE_TEST = 0;
  localparam int CTRL_RD_LOW = 1;
  localparam int CTRL_ONCE = 2;
  localparam int CTRL_HOLD = 3;
  localparam int CTRL_EXT_READY = 4;
  localparam int CTRL_INT_ACK = 5;

  // divisor code to (factor - 1)
  function automatic logic [7:0] div_last(input logic [2:0] code);
    case (code)
      3'h0: div_last = 8'h00;
      3'h1: div_last = 8'h03;
      3'h2: div_last = 8'h07;
      3'h3: div_last = 8'h0f;
      3'h4: div_last = 8'h1f;
      3'h5: div_last = 8'h3f;
      3'h6: div_last = 8'h7f;
      default: div_last = 8'hff;
    endcase
  endfunction
endpackage

/* File: verilog/refresh_link_if.sv */
// Purpose: wires between the refresh/power-save device and its bus partner
// Assumes: both ends on clk_sys
// Notes: float is shown by the shared pinOe, no tri-state here
`timescale 1ns/100ps
`default_nettype none
interface refresh_link_if;
  logic regWrite;
  logic regRead;
  logic [7:0] regAddr;
  logic [15:0] regWdata;
  logic [15:0] regRdata;
  logic regValid;
  logic refreshReq;
  logic [19:0] refreshAddr;
  logic refreshSelect;
  logic [2:0] refreshWaits;
  logic needExtReady;
  logic refreshDone;
  logic holdReq;
  logic holdAck;
  logic intAck;
  logic resetOut;
  logic testIn;
  logic readStrobeN;
  logic upperSelectN;
  logic lowerSelectN;
  logic clockOutput;
  logic pin0Out;
  logic pin1Out;
  logic pinOe;
  modport device (
    input regWrite, regRead, regAddr, regWdata, refreshDone, holdReq, intAck,
    input testIn, readStrobeN, upperSelectN, lowerSelectN,
    output regRdata, regValid, refreshReq, refreshAddr, refreshSelect, refreshWaits,
    output needExtReady, holdAck, resetOut, clockOutput, pin0Out, pin1Out, pinOe
  );
  modport host (
    output regWrite, regRead, regAddr, regWdata, refreshDone, holdReq, intAck,
    output testIn, readStrobeN, upperSelectN, lowerSelectN,
    input regRdata, regValid, refreshReq, refreshAddr, refreshSelect, refreshWaits,
    input needExtReady, holdAck, resetOut, clockOutput, pin0Out, pin1Out, pinOe
  );
endinterface
`default_nettype wire

/* File: verilog/refresh_power_unit.sv */
// Purpose: refresh unit, power-save divider and reset straps of the processor
// Assumes: register port strobes are one clk_sys cycle, same clock domain
// Notes: divided clock is modelled as a tick enable on clk_sys
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// (R1) compatible mode hides all enhanced registers
// (R2) reset output tied to test selects enhanced
// (R3) read strobe low at reset gives queue status
// (R4) refresh request each interval, enhanced only
// (R5) select hit uses its waits, else external ready
// (R6) drop hold acknowledge when refresh is needed
// (R7) requester releases hold one clock afterwards
// (R8) registers deselected in compatible; reserved bits zero
// (R9) address: partition, three zeros, row, one
// (R10) row counter steps as nine-bit LFSR
// (R11) enable loads counter, then decrements each clock
// (R12) at one: request and reload interval
// (R13) software keeps interval at eighteen or more
// (R14) disable clears counter, keeps row counter
// (R15) power-save divides clock and clock output
// (R16) divisor codes map to 1 through 256
// (R17) refresh logic runs from divided clock
// (R18) interrupt clears power-save enable bit
// (R19) division starts and ends at the write
// (R20) both memory selects low: float all pins
// (R21) partition bits clear at reset
// (R22) power-save enable clears at reset
// (R23) refresh enable resets; counter value read-only
// (R24) row counter advances after each refresh
module refresh_power_unit (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [1:0] queueStatusIn,
  input wire logic addrLatchIn,
  input wire logic writeStrobeIn,
  input wire logic selectValid,
  input wire logic [6:0] selectBase,
  input wire logic [2:0] selectWaits,
  output logic enhancedMode,
  output logic queueStatusMode,
  refresh_link_if.device link
);
  typedef enum logic {PH_STRAP, PH_RUN} phase_e;
  typedef struct packed {
    phase_e phase;
    logic [3:0] strapCnt;
    logic [4:0] syncA;
    logic [4:0] syncB;
    logic enhanced;
    logic qsMode;
    logic floatAll;
    logic resetOut;
    logic [6:0] partition;
    logic [8:0] interval;
    logic refEn;
    logic [8:0] count;
    logic [8:0] row;
    logic psEn;
    logic [2:0] divSel;
    logic [7:0] divCnt;
    logic clockOutput;
    logic pending;
    logic refreshReq;
    logic holdAck;
    logic [19:0] refreshAddr;
    logic refreshSelect;
    logic [2:0] refreshWaits;
    logic needExtReady;
    logic [15:0] regRdata;
    logic regValid;
    logic pin0Out;
    logic pin1Out;
    logic pinOe;
  } state_s;

  state_s st_q;
  state_s st_d;
  logic tick;
  logic wrEn;
  logic [7:0] lastDiv;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    // pins from the far side pass two flops; only syncB is read below
    st_d.syncA = {link.lowerSelectN, link.upperSelectN, link.readStrobeN, link.testIn,
                  link.holdReq};
    st_d.syncB = st_q.syncA;
    lastDiv = refresh_pkg::div_last(st_q.divSel); // R16
    // R15 R17: every interval counter step waits on the divided tick
    tick = !(st_q.psEn && st_q.enhanced) || (st_q.divCnt == lastDiv);
    wrEn = link.regWrite && st_q.enhanced && (st_q.phase == PH_RUN); // R1 R8
    st_d.regValid = 1'b0;

    case (st_q.phase)
      PH_STRAP: begin
        st_d.resetOut = 1'b1;
        st_d.strapCnt = st_q.strapCnt + 4'h1;
        if (st_q.strapCnt == refresh_pkg::STRAP_CYCLES) begin
          // end of the reset window stands for the rising reset edge
          st_d.phase = PH_RUN;
          st_d.resetOut = 1'b0;
          st_d.enhanced = st_q.syncB[1]; // R2
          st_d.qsMode = !st_q.syncB[2]; // R3
          st_d.floatAll = !st_q.syncB[3] && !st_q.syncB[4]; // R20
        end
      end
      PH_RUN: begin
        st_d.resetOut = 1'b0;
      end
      default: begin
        st_d.phase = PH_STRAP;
      end
    endcase

    // ---------------------------------------------------------------
    // divider
    // ---------------------------------------------------------------
    st_d.divCnt = tick ? 8'h00 : st_q.divCnt + 8'h01;
    st_d.clockOutput = (st_q.psEn && st_q.enhanced) ? (st_d.divCnt <= (lastDiv >> 1))
                                                    : 1'b1; // R15

    // ---------------------------------------------------------------
    // interval counter and request
    // ---------------------------------------------------------------
    if (st_q.refEn && st_q.enhanced && tick) begin // R4 R17
      if (st_q.count == refresh_pkg::COUNT_EXPIRE) begin
        st_d.pending = 1'b1; // R12
        st_d.count = st_q.interval; // R12
      end else begin
        st_d.count = st_q.count - 9'h001; // R11
      end
    end
    if (link.refreshDone && st_q.pending) begin
      st_d.row = {st_q.row[7:0], ^(st_q.row & refresh_pkg::ROW_TAPS)}; // R10 R24
      // a new expiry in the same cycle keeps the request
      st_d.pending = st_d.pending && !(st_q.count != refresh_pkg::COUNT_EXPIRE || !tick
                                       || !st_q.refEn);
    end

    // ---------------------------------------------------------------
    // register writes
    // ---------------------------------------------------------------
    if (wrEn) begin
      case (link.regAddr)
        refresh_pkg::OFS_PARTITION:
          st_d.partition = link.regWdata[15:refresh_pkg::PART_LSB];
        refresh_pkg::OFS_INTERVAL: st_d.interval = link.regWdata[8:0];
        refresh_pkg::OFS_ENABLE_COUNT: begin
          st_d.refEn = link.regWdata[refresh_pkg::ENABLE_BIT];
          // R11: load at the write; R14: clear, row untouched
          st_d.count = link.regWdata[refresh_pkg::ENABLE_BIT] ? st_q.interval : 9'h000;
          if (!link.regWdata[refresh_pkg::ENABLE_BIT]) begin
            st_d.pending = 1'b0; // R14
          end
        end
        refresh_pkg::OFS_POWER_SAVE: begin
          // R19: division follows the write at once
          st_d.psEn = link.regWdata[refresh_pkg::ENABLE_BIT];
          st_d.divSel = link.regWdata[refresh_pkg::DIV_MSB:0];
          st_d.divCnt = 8'h00;
        end
        default: begin
        end
      endcase
    end
    // interrupt wins over a concurrent set: full speed first
    if (link.intAck) begin
      st_d.psEn = 1'b0; // R18
    end

    // ---------------------------------------------------------------
    // register reads
    // ---------------------------------------------------------------
    if (link.regRead) begin
      st_d.regValid = 1'b1;
      st_d.regRdata = 16'h0000;
      if (st_q.enhanced) begin // R1 R8
        case (link.regAddr)
          refresh_pkg::OFS_PARTITION: st_d.regRdata = {st_q.partition, 9'h000};
          refresh_pkg::OFS_INTERVAL: st_d.regRdata = {7'h00, st_q.interval};
          refresh_pkg::OFS_ENABLE_COUNT:
            st_d.regRdata = {st_q.refEn, 6'h00, st_q.count}; // R23
          refresh_pkg::OFS_POWER_SAVE:
            st_d.regRdata = {st_q.psEn, 12'h000, st_q.divSel};
          default: st_d.regRdata = 16'h0000;
        endcase
      end
    end

    // ---------------------------------------------------------------
    // hold and refresh cycle
    // ---------------------------------------------------------------
    if (st_q.pending && st_q.holdAck) begin
      st_d.holdAck = 1'b0; // R6
    end else if (st_q.syncB[0] && !st_q.pending && !st_q.refreshReq) begin
      st_d.holdAck = 1'b1;
    end else if (!st_q.syncB[0]) begin
      st_d.holdAck = 1'b0;
    end
    st_d.refreshReq = st_d.pending && !st_d.holdAck && !link.refreshDone;
    st_d.refreshAddr = {st_q.partition, 3'h0, st_q.row, 1'b1}; // R9
    st_d.refreshSelect = selectValid && (st_q.partition == selectBase); // R5
    st_d.refreshWaits = selectWaits;
    st_d.needExtReady = !st_d.refreshSelect; // R5

    // ---------------------------------------------------------------
    // pins
    // ---------------------------------------------------------------
    st_d.pinOe = !st_d.floatAll && st_d.phase == PH_RUN; // R20
    st_d.pin0Out = st_q.qsMode ? queueStatusIn[0] : addrLatchIn; // R3
    st_d.pin1Out = st_q.qsMode ? queueStatusIn[1] : writeStrobeIn; // R3
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_q <= '0; // R21 R22 R23
      st_q.phase <= PH_STRAP;
      st_q.resetOut <= 1'b1;
      st_q.row <= refresh_pkg::ROW_RESET;
      st_q.clockOutput <= 1'b1;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign link.regRdata = st_q.regRdata;
  assign link.regValid = st_q.regValid;
  assign link.refreshReq = st_q.refreshReq;
  assign link.refreshAddr = st_q.refreshAddr;
  assign link.refreshSelect = st_q.refreshSelect;
  assign link.refreshWaits = st_q.refreshWaits;
  assign link.needExtReady = st_q.needExtReady;
  assign link.holdAck = st_q.holdAck;
  assign link.resetOut = st_q.resetOut;
  assign link.clockOutput = st_q.clockOutput;
  assign link.pin0Out = st_q.pin0Out;
  assign link.pin1Out = st_q.pin1Out;
  assign link.pinOe = st_q.pinOe;
  assign enhancedMode = st_q.enhanced;
  assign queueStatusMode = st_q.qsMode;
endmodule
`default_nettype wire

/* File: verilog/refresh_bus_partner.sv */
// Purpose: bus interface unit and hold requester facing the refresh device
// Assumes: software drives it over APB, single clock
// Notes: straps are set in the control register before reset is released
`timescale 1ns/100ps
`default_nettype none
module refresh_bus_partner (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  refresh_link_if.host link
);
  typedef enum logic [1:0] {CY_IDLE, CY_RUN, CY_DONE} cycle_e;
  typedef struct packed {
    cycle_e cyc;
    logic [2:0] waitCnt;
    logic [5:0] ctrl;
    logic [15:0] rdata;
    logic rdDone;
    logic [15:0] refreshCount;
    logic prevAck;
    logic gap;
    logic holdReq;
    logic regWrite;
    logic regRead;
    logic [7:0] regAddr;
    logic [15:0] regWdata;
    logic refreshDone;
    logic intAck;
    logic testIn;
    logic [31:0] prdata;
    logic pready;
  } state_s;

  state_s st_q;
  state_s st_d;
  logic setup;

  always_comb begin
    st_d = st_q;
    setup = psel && !penable;
    st_d.pready = setup;
    st_d.regWrite = 1'b0;
    st_d.regRead = 1'b0;
    st_d.refreshDone = 1'b0;
    st_d.intAck = 1'b0;

    // ---------------------------------------------------------------
    // APB slave: answer one cycle after setup
    // ---------------------------------------------------------------
    if (setup && !pwrite) begin
      case (paddr)
        refresh_pkg::APB_RDATA: st_d.prdata = {st_q.rdDone, 15'h0000, st_q.rdata};
        refresh_pkg::APB_CTRL: st_d.prdata = {26'h0000000, st_q.ctrl};
        refresh_pkg::APB_STATUS:
          st_d.prdata = {13'h0000, link.pinOe, link.refreshReq, link.holdAck,
                         st_q.refreshCount};
        default: st_d.prdata = 32'h00000000;
      endcase
    end
    if (psel && penable && st_q.pready && pwrite) begin
      case (paddr)
        refresh_pkg::APB_CMD: begin
          st_d.regAddr = pwdata[23:16];
          st_d.regWdata = pwdata[15:0];
          st_d.regWrite = pwdata[refresh_pkg::CMD_WRITE_BIT];
          st_d.regRead = pwdata[refresh_pkg::CMD_READ_BIT];
          if (pwdata[refresh_pkg::CMD_READ_BIT]) begin
            st_d.rdDone = 1'b0;
          end
        end
        refresh_pkg::APB_CTRL: begin
          st_d.ctrl = pwdata[5:0];
          st_d.ctrl[refresh_pkg::CTRL_INT_ACK] = 1'b0;
          st_d.intAck = pwdata[refresh_pkg::CTRL_INT_ACK];
        end
        default: begin
        end
      endcase
    end
    if (link.regValid) begin
      st_d.rdata = link.regRdata;
      st_d.rdDone = 1'b1;
    end

    // ---------------------------------------------------------------
    // straps and hold requester
    // ---------------------------------------------------------------
    st_d.testIn = st_q.ctrl[refresh_pkg::CTRL_TIE_TEST] && link.resetOut; // R2
    st_d.prevAck = link.holdAck;
    // R7: acknowledge lost while still asking: let go one clock
    st_d.gap = st_q.prevAck && !link.holdAck && st_q.holdReq;
    st_d.holdReq = st_q.ctrl[refresh_pkg::CTRL_HOLD] && !st_d.gap;

    // ---------------------------------------------------------------
    // refresh bus cycle
    // ---------------------------------------------------------------
    case (st_q.cyc)
      CY_IDLE: begin
        if (link.refreshReq && !link.holdAck) begin
          st_d.cyc = CY_RUN;
          st_d.waitCnt = link.refreshWaits;
        end
      end
      CY_RUN: begin
        if (link.needExtReady) begin
          if (st_q.ctrl[refresh_pkg::CTRL_EXT_READY]) begin // R5
            st_d.cyc = CY_DONE;
          end
        end else if (st_q.waitCnt == 3'h0) begin
          st_d.cyc = CY_DONE;
        end else begin
          st_d.waitCnt = st_q.waitCnt - 3'h1; // R5
        end
        if (st_d.cyc == CY_DONE) begin
          st_d.refreshDone = 1'b1;
          st_d.refreshCount = st_q.refreshCount + 16'h0001;
        end
      end
      CY_DONE: st_d.cyc = CY_IDLE;
      default: st_d.cyc = CY_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_q <= '0;
      st_q.cyc <= CY_IDLE;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign prdata = st_q.prdata;
  assign pready = st_q.pready;
  assign pslverr = 1'b0;
  assign link.regWrite = st_q.regWrite;
  assign link.regRead = st_q.regRead;
  assign link.regAddr = st_q.regAddr;
  assign link.regWdata = st_q.regWdata;
  assign link.refreshDone = st_q.refreshDone;
  assign link.holdReq = st_q.holdReq;
  assign link.intAck = st_q.intAck;
  assign link.testIn = st_q.testIn;
  assign link.readStrobeN = !st_q.ctrl[refresh_pkg::CTRL_RD_LOW];
  assign link.upperSelectN = !st_q.ctrl[refresh_pkg::CTRL_ONCE]; // R20
  assign link.lowerSelectN = !st_q.ctrl[refresh_pkg::CTRL_ONCE];
endmodule
`default_nettype wire

/* File: verification/refresh_link_props.sv */
// Purpose: link checks
// Assumes: device reset disables
// Notes: straps rebuilt from pins
`timescale 1ns/100ps
`default_nettype none
module refresh_link_props (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic regRead,
  input wire logic regValid,
  input wire logic [15:0] regRdata,
  input wire logic refreshReq,
  input wire logic [19:0] refreshAddr,
  input wire logic refreshSelect,
  input wire logic needExtReady,
  input wire logic refreshDone,
  input wire logic holdReq,
  input wire logic holdAck,
  input wire logic resetOut,
  input wire logic testIn,
  input wire logic upperSelectN,
  input wire logic lowerSelectN,
  input wire logic pinOe
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // ------
  // strap and row tracking
  // ------
  logic testSeen_q, compat_q, float_q;
  logic [8:0] rowNext_q;
  // sticky over the window: sync lag
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      testSeen_q <= 1'b0;
      compat_q <= 1'b0;
      float_q <= 1'b0;
      rowNext_q <= 9'h000;
    end else begin
      if (resetOut && testIn) testSeen_q <= 1'b1;
      if ($fell(resetOut)) begin
        compat_q <= !testSeen_q;
        float_q <= !upperSelectN && !lowerSelectN;
      end
      if (refreshDone) rowNext_q <= {refreshAddr[8:1], refreshAddr[9] ^ refreshAddr[5]};
    end
  end
  // ------
  // properties
  // ------
  sequence s_row_advanced;
    ##[1:4] (refreshAddr[9:1] == rowNext_q);
  endsequence
  sequence s_hold_released;
    ##[0:4] !holdReq;
  endsequence
  a_req_no_hold: assert property (refreshReq |-> !holdAck)
    else $error("request under hold");
  a_hold_gap: assert property ($fell(holdAck) && holdReq |-> s_hold_released)
    else $error("hold not released");
  a_addr_form: assert property (refreshReq |-> refreshAddr[12:10] == 3'h0 && refreshAddr[0])
    else $error("address form");
  a_ext_ready: assert property (refreshReq |-> needExtReady == !refreshSelect)
    else $error("ready mode");
  a_row_step: assert property (refreshDone |-> s_row_advanced)
    else $error("row step");
  a_req_clears: assert property (refreshDone |-> ##[1:3] !refreshReq)
    else $error("request stuck");
  a_read_answer: assert property (regRead |=> regValid)
    else $error("no read answer");
  a_compat_data: assert property (compat_q && regValid |-> regRdata == 16'h0000)
    else $error("compat read data");
  a_compat_quiet: assert property (compat_q |-> !refreshReq)
    else $error("compat request");
  a_float_hold: assert property (float_q |-> !pinOe)
    else $error("float pins");
  a_window_float: assert property (resetOut && $past(resetOut) |-> !pinOe)
    else $error("window pins");
endmodule
`default_nettype wire

/* File: verification/refresh_and_power_save_unit_test.sv */
// Purpose: refresh unit over APB
// Assumes: straps set before device reset
// Notes: device reached via CMD word
`timescale 1ns/100ps
`default_nettype none
module refresh_and_power_save_unit_test;
  localparam logic [15:0] IVAL = 16'h0012;
  logic clk_sys, rstnHost, rstnDev, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] queueStatusIn;
  logic addrLatchIn, writeStrobeIn, selectValid, enhancedMode, queueStatusMode;
  logic [6:0] selectBase;
  logic [2:0] selectWaits;
  logic [15:0] d;
  logic [8:0] row;
  int fails, checksDone, cycles, n;
  logic [7:0] rsvOfs [4] = '{8'he0, 8'he2, 8'hf0, 8'he4};
  logic [15:0] rsvWr [4] = '{16'hffff, 16'hffff, 16'h7fff, 16'h01ff};
  logic [15:0] rsvExp [4] = '{16'hfe00, 16'h01ff, 16'h0007, 16'h0000};
  refresh_link_if link();
  refresh_power_unit i_refresh_power_unit (.clk_sys(clk_sys), .rstn(rstnDev), .ce(1'b1),
    .queueStatusIn(queueStatusIn), .addrLatchIn(addrLatchIn), .writeStrobeIn(writeStrobeIn),
    .selectValid(selectValid), .selectBase(selectBase), .selectWaits(selectWaits),
    .enhancedMode(enhancedMode), .queueStatusMode(queueStatusMode), .link(link));
  refresh_bus_partner i_refresh_bus_partner (.clk_sys(clk_sys), .rstn(rstnHost), .ce(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
  refresh_link_props i_refresh_link_props (.clk_sys(clk_sys), .rstn(rstnDev),
    .regRead(link.regRead), .regValid(link.regValid), .regRdata(link.regRdata),
    .refreshReq(link.refreshReq), .refreshAddr(link.refreshAddr),
    .refreshSelect(link.refreshSelect), .needExtReady(link.needExtReady),
    .refreshDone(link.refreshDone), .holdReq(link.holdReq), .holdAck(link.holdAck),
    .resetOut(link.resetOut), .testIn(link.testIn), .upperSelectN(link.upperSelectN),
    .lowerSelectN(link.lowerSelectN), .pinOe(link.pinOe));
  // ------
  // clock, watchdog, helpers
  // ------
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 40000) begin
      fails++;
      $display("[ERR] cycles expected %0d seen %0d", 40000, cycles);
      giveVerdict();
    end
  end
  function automatic logic [8:0] step(input logic [8:0] r);
    return {r[7:0], r[8] ^ r[4]};
  endfunction
  function automatic logic sigOf(input int w);
    return (w == 0) ? link.clockOutput : (w == 1) ? link.refreshReq : link.holdAck;
  endfunction
  task automatic giveVerdict();
    $display("checks %0d mismatches %0d", checksDone, fails);
    if (fails == 0 && checksDone > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checksDone++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // held until pready high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int k;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(negedge clk_sys);
    for (k = 0; k < 50 && pready !== 1'b1; k++) @(negedge clk_sys);
    chk("pready", 32'h1, 32'(pready));
    rd = prdata;
    @(posedge clk_sys);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic devWrite(input logic [7:0] off, input logic [15:0] v);
    apb(1'b1, refresh_pkg::APB_CMD, {6'h00, 2'b01, off, v});
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic devRead(input logic [7:0] off);
    apb(1'b1, refresh_pkg::APB_CMD, {6'h00, 2'b10, off, 16'h0000});
    repeat (4) @(posedge clk_sys);
    for (int i = 0; i < 20; i++) begin
      apb(1'b0, refresh_pkg::APB_RDATA, 32'h0);
      if (rd[31] === 1'b1) break;
    end
    d = rd[15:0];
  endtask
  task automatic ctrl(input logic [5:0] v);
    apb(1'b1, refresh_pkg::APB_CTRL, {26'h0, v});
  endtask
  task automatic devReset(input logic [5:0] v);
    ctrl(v);
    rstnDev <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rstnDev <= 1'b1;
    repeat (20) @(posedge clk_sys);
  endtask
  // falling edges until level
  task automatic waitFor(input int w, input logic lvl, output int c);
    c = 0;
    do begin
      @(negedge clk_sys);
      c++;
    end while (sigOf(w) !== lvl && c < 600);
    if (c >= 600) begin
      fails++;
      $display("[ERR] wait %0d expected %b seen timeout", w, lvl);
    end
  endtask
  task automatic riseGap(input int w, output int g);
    int a, b;
    waitFor(w, 1'b0, a);
    waitFor(w, 1'b1, a);
    waitFor(w, 1'b0, a);
    waitFor(w, 1'b1, b);
    g = a + b;
  endtask
  // ------
  // main sequence
  // ------
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {rstnHost, rstnDev, selectValid, selectBase, selectWaits} = '0;
    queueStatusIn = 2'b10;
    addrLatchIn = 1'b1;
    writeStrobeIn = 1'b0;
    repeat (20) @(posedge clk_sys);
    rstnHost <= 1'b1;
    devReset(6'h00);
    chk("enhanced", 32'h0, 32'(enhancedMode));
    chk("qs mode", 32'h0, 32'(queueStatusMode));
    chk("pins", 32'h1, 32'({link.pin1Out, link.pin0Out}));
    chk("pin oe", 32'h1, 32'(link.pinOe));
    devWrite(8'he0, 16'hfe00);
    devRead(8'he0);
    chk("compat part", 32'h0, 32'(d));
    devWrite(8'he4, 16'h8000);
    repeat (40) @(posedge clk_sys);
    chk("compat req", 32'h0, 32'(link.refreshReq));
    devReset(6'h07);
    repeat (30) @(posedge clk_sys);
    chk("float", 32'h0, 32'(link.pinOe));
    devReset(6'h03);
    chk("enhanced", 32'h1, 32'(enhancedMode));
    chk("qs pins", 32'h2, 32'({link.pin1Out, link.pin0Out}));
    for (int i = 1; i < 4; i++) begin
      devRead(rsvOfs[(i == 1) ? 0 : i]);
      chk("reset value", 32'h0, 32'(d));
    end
    for (int i = 0; i < 4; i++) begin
      devWrite(rsvOfs[i], rsvWr[i]);
      devRead(rsvOfs[i]);
      chk("reserved", 32'(rsvExp[i]), 32'(d));
    end
    devWrite(8'hf0, 16'h0000);
    devWrite(8'he0, 16'ha400);
    devWrite(8'he2, IVAL);
    selectValid <= 1'b1;
    selectBase <= 7'h52;
    selectWaits <= 3'h2;
    devWrite(8'he4, 16'h8000);
    waitFor(1, 1'b1, n);
    chk("addr", 32'({7'h52, 3'h0, 9'h001, 1'b1}), 32'(link.refreshAddr));
    chk("select", 32'h1, 32'(link.refreshSelect));
    chk("waits", 32'h2, 32'(link.refreshWaits));
    riseGap(1, n);
    chk("interval", 32'(IVAL), 32'(n));
    chk("row", 32'(step(step(9'h001))), 32'(link.refreshAddr[9:1]));
    waitFor(1, 1'b0, n);
    apb(1'b0, refresh_pkg::APB_STATUS, 32'h0);
    chk("done count", 32'h3, 32'(rd[15:0]));
    selectValid <= 1'b0;
    waitFor(1, 1'b1, n);
    chk("ext ready", 32'h1, 32'(link.needExtReady));
    repeat (30) @(posedge clk_sys);
    chk("ext wait", 32'h1, 32'(link.refreshReq));
    ctrl(6'h13);
    waitFor(1, 1'b0, n);
    ctrl(6'h03);
    selectValid <= 1'b1;
    ctrl(6'h0b);
    waitFor(2, 1'b1, n);
    waitFor(1, 1'b1, n);
    chk("hold drop", 32'h0, 32'(link.holdAck));
    ctrl(6'h03);
    devWrite(8'he4, 16'h0000);
    repeat (10) @(posedge clk_sys);
    row = link.refreshAddr[9:1];
    devRead(8'he4);
    chk("disabled", 32'h0, 32'(d));
    repeat (60) @(posedge clk_sys);
    chk("no req", 32'h0, 32'(link.refreshReq));
    chk("row kept", 32'(row), 32'(link.refreshAddr[9:1]));
    for (int c = 1; c < 8; c++) begin
      devWrite(8'hf0, 16'h8000 | 16'(c));
      riseGap(0, n);
      chk("divide", 32'(2 << c), 32'(n));
    end
    devWrite(8'hf0, 16'h8000);
    chk("divide one", 32'h1, 32'(link.clockOutput));
    devWrite(8'hf0, 16'h8003);
    ctrl(6'h23);
    devRead(8'hf0);
    chk("int clears", 32'h3, 32'(d));
    repeat (5) @(posedge clk_sys);
    chk("full speed", 32'h1, 32'(link.clockOutput));
    giveVerdict();
  end
endmodule
`default_nettype wire
